// file: verilog/shunt_cal_consts.svh
// constants for the shunt channel calibration and overcurrent block
// assumes: included by the package and by every design file that needs a figure
`ifndef SHUNT_CAL_CONSTS_SVH
`define SHUNT_CAL_CONSTS_SVH
// register indices, byte address is four times the index
`define IDX_OCAL_UPPER 8'hc4
`define IDX_OCAL_LOWER 8'hc5
`define IDX_GAIN_CAL 8'hc6
`define IDX_OC_CONFIG 8'hc7
`define IDX_HIGH_TH 8'hc8
`define IDX_LOW_TH 8'hc9
`define IDX_OC_STATUS 8'hd0
// reset values
`define RST_OCAL 24'h00_0000
`define RST_GAIN 16'h0000
`define RST_HIGH_TH 16'h7fff
`define RST_LOW_TH 16'h8000
// config field positions
`define CFG_EN_BIT 15
`define CFG_POL_BIT 14
`define CFG_RSV_BIT 13
`define CFG_NUM_HI 12
`define CFG_NUM_LO 8
// calibration arithmetic
`define GAIN_UNITY 18'h1_0000
`define CAL_MAX 24'h7f_ffff
`define CAL_MIN 24'h80_0000
// fast filter: log2 of the fixed ratio, outputs dropped after start
`define FAST_OSR_LOG2 6
`define FAST_SETTLE 2'h2
`define FAST_MAX 16'h7fff
// deglitch code breakpoints and step bases
`define DGL_CODE_LIN 5'h09
`define DGL_CODE_STEP2 5'h12
`define DGL_CODE_STEP8 5'h13
`define DGL_OFS_STEP2 8'h08
`define DGL_BASE_STEP8 8'h20
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: verilog/shunt_cal_pkg.sv
// types shared by the calibration block and its fast filter
// assumes: the constants header sits beside this file
`include "shunt_cal_consts.svh"
package shunt_cal_pkg;
    // write channel state, gray along idle -> respond
    typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_RESP = 2'b01} wr_state_t;
    typedef logic signed [15:0] fast_word_t;
    typedef logic [7:0] dgl_count_t;
endpackage

// file: verilog/sinc3_fast_filter.sv
// third-order sinc decimator for the overcurrent fast path
// assumes: modulator bit arrives on the same clock, one bit per edge
`timescale 1ns/1ns
`include "shunt_cal_consts.svh"
module sinc3_fast_filter
    import shunt_cal_pkg::*;
#(
    parameter int OSR_LOG2 = `FAST_OSR_LOG2
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic mod_bit,
    output fast_word_t fast_data,
    output logic fast_valid
);
    localparam int ACC_W = 3 * OSR_LOG2 + 1;
    localparam int SHIFT = 3 * OSR_LOG2 - 16;
    localparam logic [ACC_W-1:0] HALF = ACC_W'(1) << (3 * OSR_LOG2 - 1);

    logic [ACC_W-1:0] int1_ff, int2_ff, int3_ff; // integrator chain
    logic [ACC_W-1:0] dly1_ff, dly2_ff, dly3_ff; // comb delay taps
    logic [OSR_LOG2-1:0] phase_ff; // decimation phase
    logic [1:0] settle_ff; // outputs dropped so far, data good once it reaches FAST_SETTLE
    logic [ACC_W-1:0] cmb1, cmb2, cmb3;
    logic signed [ACC_W-1:0] centered, shifted;
    logic decim;

    // modular wraparound in the integrators is harmless for a sinc
    assign cmb1 = int3_ff - dly1_ff;
    assign cmb2 = cmb1 - dly2_ff;
    assign cmb3 = cmb2 - dly3_ff;
    assign centered = $signed(cmb3 - HALF);
    assign shifted = centered >>> SHIFT;
    assign decim = &phase_ff;

    // integrators run every edge while enabled
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            int1_ff <= '0;
            int2_ff <= '0;
            int3_ff <= '0;
            phase_ff <= '0;
        end
        else
        begin
            int1_ff <= int1_ff + ACC_W'(mod_bit);
            int2_ff <= int2_ff + int1_ff;
            int3_ff <= int3_ff + int2_ff;
            phase_ff <= phase_ff + 1'b1;
        end
    end

    // combs and output word once per decimation period
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            dly1_ff <= '0;
            dly2_ff <= '0;
            dly3_ff <= '0;
            settle_ff <= '0;
            fast_data <= '0;
            fast_valid <= 1'b0;
        end
        else
        begin
            fast_valid <= 1'b0;
            if (decim)
            begin
                dly1_ff <= int3_ff;
                dly2_ff <= cmb1;
                dly3_ff <= cmb2;
                // first words carry start-up transient, keep them back
                if (settle_ff != `FAST_SETTLE)
                    settle_ff <= settle_ff + 1'b1;
                else
                begin
                    fast_valid <= 1'b1;
                    // all-ones stream lands one past positive full scale
                    if (shifted > $signed(ACC_W'(`FAST_MAX)))
                        fast_data <= `FAST_MAX;
                    else
                        fast_data <= shifted[15:0];
                end
            end
        end
    end
endmodule

// file: verilog/shunt_adc_cal_and_overcurrent.sv
// second shunt channel: offset/gain calibration and fast overcurrent comparator
// assumes: modulator bit, raw result and pin settings come from CLK logic
`timescale 1ns/1ns
`include "shunt_cal_consts.svh"
module shunt_adc_cal_and_overcurrent
    import shunt_cal_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic MOD_BIT,
    input wire logic CONV_ENABLE,
    input wire logic [23:0] RAW_DATA,
    input wire logic RAW_VALID,
    output logic [23:0] CAL_DATA,
    output logic CAL_VALID,
    input wire logic SHARED_PIN_SOURCE_SEL,
    input wire logic SHARED_PIN_FORMAT_SEL,
    output logic FAULT_PIN_O,
    output logic FAULT_PIN_OE
);
    // software-visible state
    logic [15:0] offset_cal_upper_ff; // offset bits 23..8
    logic [7:0] offset_cal_lower_ff; // offset bits 7..0
    logic [15:0] gain_cal_value_ff;
    logic overcurrent_enable_ff;
    logic fault_pin_polarity_ff;
    logic cfg_spare_ff; // writable spare bit, no effect
    logic [4:0] deglitch_count_sel_ff;
    logic [15:0] high_threshold_ff;
    logic [15:0] low_threshold_ff;

    // bus slave state
    wr_state_t wr_state_ff, nxt_wr_state;
    logic aw_got_ff, nxt_aw_got;
    logic w_got_ff, nxt_w_got;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic nxt_rvalid;
    logic do_write;
    logic [8:0] wr_dec, rd_dec; // {hit range, index}

    // fast path
    logic fast_run;
    fast_word_t fast_data;
    logic fast_valid;
    logic [1:0] beyond; // [0] high side, [1] low side
    dgl_count_t cnt_ff [2];
    logic [1:0] trip_ff; // [0] high_trip_flag, [1] low_trip_flag
    dgl_count_t target;
    logic fault;

    // calibration path
    logic [23:0] offset_cal_value;
    logic signed [24:0] offs_corr;
    logic signed [17:0] gain_mult;
    logic signed [42:0] product;
    logic signed [26:0] scaled;

    // byte address to register index; range bit clear means unmapped upper bits
    function automatic logic [8:0] idx_of(input logic [ADDR_W-1:0] a);
        idx_of = {~|a[ADDR_W-1:10], a[9:2]};
    endfunction

    // merge one 16-bit register with the low two byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // deglitch code to consecutive-result count
    function automatic dgl_count_t deglitch_target(input logic [4:0] c);
        if (c <= `DGL_CODE_LIN)
            deglitch_target = 8'(c) + 8'h01; // linear 1..10
        else if (c <= `DGL_CODE_STEP2)
            deglitch_target = 8'({3'h0, c} << 1) - `DGL_OFS_STEP2; // steps of 2
        else
            deglitch_target = `DGL_BASE_STEP8 + 8'(8'(c - `DGL_CODE_STEP8) << 3);
    endfunction

    // saturate the scaled product to the output word
    function automatic logic [23:0] sat24(input logic signed [26:0] v);
        if (v > $signed({3'b000, `CAL_MAX}))
            sat24 = `CAL_MAX;
        else if (v < $signed({3'b111, `CAL_MIN}))
            sat24 = `CAL_MIN;
        else
            sat24 = v[23:0];
    endfunction

    // write channel next state; address and data may arrive in either order
    always_comb
    begin
        do_write = (wr_state_ff == WR_IDLE) && aw_got_ff && w_got_ff;
        nxt_wr_state = wr_state_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        case (wr_state_ff)
            WR_IDLE:
            begin
                if (do_write)
                begin
                    nxt_wr_state = WR_RESP;
                    nxt_aw_got = 1'b0;
                    nxt_w_got = 1'b0;
                end
                else
                begin
                    if (AWVALID && AWREADY)
                        nxt_aw_got = 1'b1;
                    if (WVALID && WREADY)
                        nxt_w_got = 1'b1;
                end
            end
            WR_RESP:
            begin
                if (BREADY)
                    nxt_wr_state = WR_IDLE;
            end
            default:
            begin
                nxt_wr_state = WR_IDLE;
            end
        endcase
    end

    assign wr_dec = idx_of(aw_addr_ff);
    assign rd_dec = idx_of(ARADDR);
    assign nxt_rvalid = RVALID ? !RREADY : (ARVALID && ARREADY);

    // write channel handshake registers
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            wr_state_ff <= WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
            aw_addr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end
        else
        begin
            wr_state_ff <= nxt_wr_state;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            // ready only while the slot is free, so nothing is overrun
            AWREADY <= (nxt_wr_state == WR_IDLE) && !nxt_aw_got;
            WREADY <= (nxt_wr_state == WR_IDLE) && !nxt_w_got;
            BVALID <= (nxt_wr_state == WR_RESP);
            if (AWVALID && AWREADY)
                aw_addr_ff <= AWADDR;
            if (WVALID && WREADY)
            begin
                wdata_ff <= WDATA;
                wstrb_ff <= WSTRB;
            end
            if (do_write)
            begin
                case (wr_dec[7:0])
                    `IDX_OCAL_UPPER, `IDX_OCAL_LOWER, `IDX_GAIN_CAL,
                    `IDX_OC_CONFIG, `IDX_HIGH_TH, `IDX_LOW_TH, `IDX_OC_STATUS:
                        BRESP <= wr_dec[8] ? `RESP_OKAY : `RESP_SLVERR;
                    default:
                        BRESP <= `RESP_SLVERR;
                endcase
            end
        end
    end

    // register writes; status is read-only and silently keeps its value
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            offset_cal_upper_ff <= 16'(`RST_OCAL >> 8);
            offset_cal_lower_ff <= 8'(`RST_OCAL);
            gain_cal_value_ff <= `RST_GAIN;
            overcurrent_enable_ff <= 1'b0;
            fault_pin_polarity_ff <= 1'b0;
            cfg_spare_ff <= 1'b0;
            deglitch_count_sel_ff <= '0;
            high_threshold_ff <= `RST_HIGH_TH;
            low_threshold_ff <= `RST_LOW_TH;
        end
        else if (do_write && wr_dec[8])
        begin
            case (wr_dec[7:0])
                `IDX_OCAL_UPPER:
                    offset_cal_upper_ff <= merge16(offset_cal_upper_ff, wdata_ff,
                                                   wstrb_ff);
                `IDX_OCAL_LOWER:
                begin
                    // only the upper byte holds offset bits; low byte reserved
                    if (wstrb_ff[1])
                        offset_cal_lower_ff <= wdata_ff[15:8];
                end
                `IDX_GAIN_CAL:
                    gain_cal_value_ff <= merge16(gain_cal_value_ff, wdata_ff, wstrb_ff);
                `IDX_OC_CONFIG:
                begin
                    // bits 7..0 are read-only zero, so only lane 1 matters
                    if (wstrb_ff[1])
                    begin
                        overcurrent_enable_ff <= wdata_ff[`CFG_EN_BIT];
                        fault_pin_polarity_ff <= wdata_ff[`CFG_POL_BIT];
                        cfg_spare_ff <= wdata_ff[`CFG_RSV_BIT];
                        deglitch_count_sel_ff <= wdata_ff[`CFG_NUM_HI:`CFG_NUM_LO];
                    end
                end
                `IDX_HIGH_TH:
                    high_threshold_ff <= merge16(high_threshold_ff, wdata_ff, wstrb_ff);
                `IDX_LOW_TH:
                    low_threshold_ff <= merge16(low_threshold_ff, wdata_ff, wstrb_ff);
                default:
                begin
                    // status and unmapped: nothing stored
                end
            endcase
        end
    end

    // read channel: data latched at the address handshake
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `RESP_OKAY;
        end
        else
        begin
            ARREADY <= !nxt_rvalid;
            RVALID <= nxt_rvalid;
            if (ARVALID && ARREADY)
            begin
                RRESP <= rd_dec[8] ? `RESP_OKAY : `RESP_SLVERR;
                RDATA <= '0;
                if (rd_dec[8])
                begin
                    case (rd_dec[7:0])
                        `IDX_OCAL_UPPER:
                            RDATA[15:0] <= offset_cal_upper_ff;
                        `IDX_OCAL_LOWER:
                            RDATA[15:8] <= offset_cal_lower_ff;
                        `IDX_GAIN_CAL:
                            RDATA[15:0] <= gain_cal_value_ff;
                        `IDX_OC_CONFIG:
                            RDATA[15:8] <= {overcurrent_enable_ff, fault_pin_polarity_ff,
                                            cfg_spare_ff, deglitch_count_sel_ff};
                        `IDX_HIGH_TH:
                            RDATA[15:0] <= high_threshold_ff;
                        `IDX_LOW_TH:
                            RDATA[15:0] <= low_threshold_ff;
                        `IDX_OC_STATUS:
                            RDATA <= {fast_data, 14'h0000, trip_ff};
                        default:
                            RRESP <= `RESP_SLVERR;
                    endcase
                end
            end
        end
    end

    // calibration: offset first so gain scales the corrected value
    assign offset_cal_value = {offset_cal_upper_ff, offset_cal_lower_ff};
    assign offs_corr = $signed({RAW_DATA[23], RAW_DATA})
                     - $signed({offset_cal_value[23], offset_cal_value});
    assign gain_mult = `GAIN_UNITY + {{2{gain_cal_value_ff[15]}}, gain_cal_value_ff};
    assign product = offs_corr * gain_mult;
    assign scaled = product[42:16]; // drop the 2^16 fraction of the gain

    // corrected result, one cycle after the raw word
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            CAL_DATA <= '0;
            CAL_VALID <= 1'b0;
        end
        else
        begin
            CAL_VALID <= RAW_VALID;
            if (RAW_VALID)
                CAL_DATA <= sat24(scaled);
        end
    end

    // CONV_ENABLE and the enable bit are the start/stop terms: the fast path is free-running while both are set
    assign fast_run = overcurrent_enable_ff && CONV_ENABLE;

    sinc3_fast_filter #(
        .OSR_LOG2(`FAST_OSR_LOG2)
    ) u_fast (
        .clk(CLK),
        .rst(SYS_RST),
        .run(fast_run),
        .mod_bit(MOD_BIT),
        .fast_data(fast_data),
        .fast_valid(fast_valid)
    );

    // full-scale thresholds switch the side off outright
    assign beyond[0] = (fast_data > $signed(high_threshold_ff))
                     && (high_threshold_ff != `RST_HIGH_TH);
    assign beyond[1] = (fast_data < $signed(low_threshold_ff))
                     && (low_threshold_ff != `RST_LOW_TH);
    assign target = deglitch_target(deglitch_count_sel_ff);

    // deglitch counters, one per side; no hysteresis, any good word restarts
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !fast_run)
        begin
            cnt_ff[0] <= '0;
            cnt_ff[1] <= '0;
            trip_ff <= '0;
        end
        else if (fast_valid)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (beyond[i])
                begin
                    // hold at target so a long fault cannot wrap the count
                    if (cnt_ff[i] < target)
                    begin
                        cnt_ff[i] <= 8'(cnt_ff[i] + 8'h01);
                        trip_ff[i] <= (8'(cnt_ff[i] + 8'h01) >= target);
                    end
                    else
                        trip_ff[i] <= 1'b1;
                end
                else
                begin
                    cnt_ff[i] <= '0;
                    trip_ff[i] <= 1'b0;
                end
            end
        end
    end

    assign fault = |trip_ff;

    // fault pin: owned by the shared pin only when its source picks us
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            FAULT_PIN_O <= 1'b0;
            FAULT_PIN_OE <= 1'b0;
        end
        else if (!SHARED_PIN_SOURCE_SEL)
        begin
            FAULT_PIN_O <= 1'b0;
            FAULT_PIN_OE <= 1'b0;
        end
        else if (!SHARED_PIN_FORMAT_SEL)
        begin
            // push-pull drives both levels
            FAULT_PIN_O <= fault_pin_polarity_ff ? fault : !fault;
            FAULT_PIN_OE <= 1'b1;
        end
        else
        begin
            // open drain can only pull low, release means high
            FAULT_PIN_O <= 1'b0;
            FAULT_PIN_OE <= fault_pin_polarity_ff ? !fault : fault;
        end
    end

    default clocking dc @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // sampled reset in the antecedent: the releasing edge still resets the pin
    a_fault_level: assert property (
        (!SYS_RST && SHARED_PIN_SOURCE_SEL && !SHARED_PIN_FORMAT_SEL) |=> FAULT_PIN_OE
        && (FAULT_PIN_O == ($past(fault_pin_polarity_ff) ? $past(fault) : !$past(fault))))
        else $error("fault pin level wrong for polarity");
    a_open_drain: assert property (
        (!SYS_RST && SHARED_PIN_SOURCE_SEL && SHARED_PIN_FORMAT_SEL) |=> !FAULT_PIN_O
        && (FAULT_PIN_OE == ($past(fault_pin_polarity_ff) ? !$past(fault) : $past(fault))))
        else $error("open drain fault pin drive wrong");
    a_lower_reserved: assert property (
        (ARVALID && ARREADY && rd_dec == {1'b1, `IDX_OCAL_LOWER}) |=>
        (RDATA[7:0] == 8'h00) && (RDATA[15:8] == offset_cal_lower_ff))
        else $error("lower offset register read wrong");
    a_high_disabled: assert property (
        (fast_valid && high_threshold_ff == `RST_HIGH_TH) |=> !trip_ff[0])
        else $error("high trip while high detection disabled");
    a_low_disabled: assert property (
        (fast_valid && low_threshold_ff == `RST_LOW_TH) |=> !trip_ff[1])
        else $error("low trip while low detection disabled");
    a_deglitch_restart: assert property (
        (fast_run && fast_valid && !beyond[0]) |=> (cnt_ff[0] == 8'h00) && !trip_ff[0])
        else $error("deglitch counter not restarted");
    a_trip_count: assert property (
        $rose(trip_ff[0]) |-> $past(fast_valid) && (cnt_ff[0] >= $past(target)))
        else $error("high trip before deglitch count reached");
    a_run_gate: assert property (
        !fast_run |=> (trip_ff == 2'b00) && (cnt_ff[1] == 8'h00))
        else $error("comparator active while disabled");
    a_cal_unity: assert property (
        (RAW_VALID && offset_cal_value == `RST_OCAL && gain_cal_value_ff == `RST_GAIN)
        |=> CAL_VALID && (CAL_DATA == $past(RAW_DATA)))
        else $error("unity calibration changed the result");
    a_write_resp: assert property (do_write |=> BVALID [*1] ##0 !AWREADY)
        else $error("write response missing");

    c_high_trip: cover property ($rose(trip_ff[0]));
    c_low_trip: cover property ($rose(trip_ff[1]));
    c_write: cover property (do_write && wr_dec == {1'b1, `IDX_OC_CONFIG});
    c_cal_out: cover property (CAL_VALID && gain_cal_value_ff != `RST_GAIN);
endmodule

// file: tb/shunt_adc_cal_and_overcurrent_tb_top.sv
// self-checking bench for the shunt calibration and overcurrent block
// assumes: design files compiled first; bench drives every port itself
`timescale 1ns/1ns
module shunt_adc_cal_and_overcurrent_tb_top;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
// signals share the port names so that .* wires them by name
logic CLK = 0;
logic SYS_RST = 1;
logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
logic [11:0] AWADDR = 0, ARADDR = 0;
logic [31:0] WDATA = 0;
logic [3:0] WSTRB = 0;
logic MOD_BIT = 0, CONV_ENABLE = 1, RAW_VALID = 0;
logic SHARED_PIN_SOURCE_SEL = 1, SHARED_PIN_FORMAT_SEL = 0;
logic [23:0] RAW_DATA = 0;
logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CAL_VALID, FAULT_PIN_O, FAULT_PIN_OE;
logic [1:0] BRESP, RRESP;
logic [31:0] RDATA;
logic [23:0] CAL_DATA;
logic [1:0] mode = 0; // bit1 alternate, else constant bit0
int errors = 0, num_checks = 0, cyc = 0;
shunt_adc_cal_and_overcurrent i_dut (.*);
always #25 CLK = ~CLK;
// modulator stream: alternating bits give a mid-scale filter word
always @(posedge CLK) MOD_BIT <= mode[1] ? ~MOD_BIT : mode[0];
// hang guard, well above the few thousand cycles the run needs
always @(posedge CLK)
begin
    cyc++;
    if (cyc == 30000)
    begin
        errors++;
        print_verdict();
    end
end
task automatic wr(input logic [11:0] a, input logic [15:0] v, input logic [1:0] er);
    logic aw, w, ta, tw;
    aw = 1;
    w = 1;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= {16'h0000, v};
    WSTRB <= 4'h3;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    // each channel released only at the edge that takes it
    while (aw || w)
    begin
        @(negedge CLK);
        ta = aw && AWREADY;
        tw = w && WREADY;
        @(posedge CLK);
        if (ta) AWVALID <= 0;
        if (tw) WVALID <= 0;
        aw = aw && !ta;
        w = w && !tw;
    end
    do @(negedge CLK); while (!BVALID);
    `CHK("bresp", er, BRESP)
    @(posedge CLK);
    BREADY <= 0;
endtask
task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do @(negedge CLK); while (!ARREADY);
    @(posedge CLK);
    ARVALID <= 0;
    do @(negedge CLK); while (!RVALID);
    `CHK("rdata", e, RDATA & m)
    `CHK("rresp", er, RRESP)
    @(posedge CLK);
    RREADY <= 0;
endtask
task automatic cal(input logic [15:0] ou, ol, g, input logic [23:0] raw, e);
    wr(12'h310, ou, 2'h0);
    wr(12'h314, ol, 2'h0);
    wr(12'h318, g, 2'h0);
    @(posedge CLK);
    RAW_DATA <= raw;
    RAW_VALID <= 1;
    @(posedge CLK);
    RAW_VALID <= 0;
    do @(negedge CLK); while (!CAL_VALID);
    `CHK("cal_data", e, CAL_DATA)
endtask
// disable first so the filter restarts, enable write last
task automatic oc(input logic [15:0] cfg, hi, lo, input logic [1:0] m);
    wr(12'h31c, 16'h0000, 2'h0);
    wr(12'h320, hi, 2'h0);
    wr(12'h324, lo, 2'h0);
    mode <= m;
    wr(12'h31c, cfg, 2'h0);
endtask
// status bits 1:0 and the pin; pin level only judged while driven
task automatic chk(input int n, input logic [1:0] fl, input logic o, oe);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
    `CHK("fault_oe", oe, FAULT_PIN_OE)
    if (oe) `CHK("fault_o", o, FAULT_PIN_O)
    rd(12'h340, 32'h0000_0003, {30'h0, fl}, 2'h0);
endtask
task print_verdict;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
initial
begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 0;
    rd(12'h310, 32'hffff_ffff, 32'h0000_0000, 2'h0);
    rd(12'h318, 32'hffff_ffff, 32'h0000_0000, 2'h0);
    rd(12'h320, 32'hffff_ffff, 32'h0000_7fff, 2'h0);
    rd(12'h324, 32'hffff_ffff, 32'h0000_8000, 2'h0);
    rd(12'h3fc, 32'hffff_ffff, 32'h0000_0000, 2'h2);
    wr(12'h314, 16'hffff, 2'h0);
    rd(12'h314, 32'hffff_ffff, 32'h0000_ff00, 2'h0);
    wr(12'h31c, 16'h3fff, 2'h0);
    rd(12'h31c, 32'hffff_ffff, 32'h0000_3f00, 2'h0);
    wr(12'h3fc, 16'h1234, 2'h2);
    cal(16'h0001, 16'h0000, 16'h0000, 24'h00_0500, 24'h00_0400);
    cal(16'h0000, 16'h0300, 16'h0000, 24'h00_0010, 24'h00_000d);
    cal(16'h0000, 16'h0000, 16'h8000, 24'h00_0800, 24'h00_0400);
    cal(16'h0000, 16'h0000, 16'h7fff, 24'h01_0000, 24'h01_7fff);
    cal(16'h0000, 16'h0000, 16'h7fff, 24'h70_0000, 24'h7f_ffff);
    cal(16'h0001, 16'h0000, 16'h0000, 24'h80_0000, 24'h80_0000);
    cal(16'h0000, 16'h0000, 16'h0000, 24'h12_3456, 24'h12_3456);
    oc(16'hc000, 16'h0000, 16'h8000, 2'b01);
    chk(208, 2'b01, 1'b1, 1'b1);
    oc(16'h8100, 16'h0000, 16'h8000, 2'b01);
    chk(208, 2'b00, 1'b1, 1'b1);
    chk(64, 2'b01, 1'b0, 1'b1);
    mode <= 2'b10;
    chk(300, 2'b00, 1'b1, 1'b1);
    // code 0x0a asks for 12 results: 11 seen by the first check, 12 by the second
    oc(16'h8a00, 16'h0000, 16'h8000, 2'b01);
    chk(850, 2'b00, 1'b1, 1'b1);
    chk(64, 2'b01, 1'b0, 1'b1);
    oc(16'hc000, 16'h7fff, 16'h8000, 2'b01);
    chk(300, 2'b00, 1'b0, 1'b1);
    oc(16'hc000, 16'h7fff, 16'h8000, 2'b00);
    chk(300, 2'b00, 1'b0, 1'b1);
    oc(16'hc000, 16'h7fff, 16'hff00, 2'b00);
    chk(208, 2'b10, 1'b1, 1'b1);
    CONV_ENABLE <= 0;
    chk(8, 2'b00, 1'b0, 1'b1);
    CONV_ENABLE <= 1;
    SHARED_PIN_FORMAT_SEL <= 1;
    oc(16'h8000, 16'h7fff, 16'hff00, 2'b00);
    chk(208, 2'b10, 1'b0, 1'b1);
    oc(16'hc000, 16'h7fff, 16'hff00, 2'b00);
    chk(208, 2'b10, 1'b0, 1'b0);
    SHARED_PIN_SOURCE_SEL <= 0;
    chk(4, 2'b10, 1'b0, 1'b0);
    // all-zero stream settles at negative full scale in the status word
    rd(12'h340, 32'hffff_0000, 32'h8000_0000, 2'h0);
    print_verdict();
end
endmodule
